// File: cpsr_pkg.sv
// package: constants, field layout and carriers for the cpu status and register file block
package cpsr_pkg;

	//------------------------------------------------------------
	// widths and counts
	//------------------------------------------------------------
	localparam int REG_COUNT      = 32;
	localparam int REG_AW         = 5;
	localparam int DATA_W         = 8;
	localparam int WORD_W         = 16;
	localparam int DADDR_W        = 16;
	localparam int IOADDR_W       = 6;
	localparam int IRQ_COUNT      = 8;
	localparam int IRQ_IDX_W      = 3;

	//------------------------------------------------------------
	// address map
	//------------------------------------------------------------
	localparam logic [IOADDR_W-1:0] IO_STATUS_FLAGS = 6'h3f;
	localparam logic [DADDR_W-1:0]  DS_IO_BASE      = 16'h0020;
	localparam logic [DADDR_W-1:0]  DS_IO_LAST      = 16'h005f;
	localparam logic [DADDR_W-1:0]  DS_REG_LAST     = 16'h001f;
	localparam logic [REG_AW-1:0]   PTR_X_LOW       = 5'h1a;
	localparam logic [REG_AW-1:0]   PTR_Y_LOW       = 5'h1c;
	localparam logic [REG_AW-1:0]   PTR_Z_LOW       = 5'h1e;
	localparam logic [DATA_W-1:0]   STATUS_RESET    = 8'h00;
	localparam logic [WORD_W-1:0]   STACK_RESET     = 16'h085f;
	localparam logic [WORD_W-1:0]   PC_RESET        = 16'h0000;

	//------------------------------------------------------------
	// status flag bit positions
	//------------------------------------------------------------
	localparam int FLAG_I = 7;
	localparam int FLAG_T = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_S = 4;
	localparam int FLAG_V = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;

	localparam logic [WORD_W-1:0] PC_STEP1 = 16'h0001;
	localparam logic [WORD_W-1:0] PC_STEP2 = 16'h0002;

	//------------------------------------------------------------
	// types
	//------------------------------------------------------------
	// port scheme of one register file access
	typedef enum logic [1:0] {
		CPSR_ONE8_RES8,
		CPSR_TWO8_RES8,
		CPSR_TWO8_RES16,
		CPSR_ONE16_RES16
	} cpsr_scheme_t;

	// global interrupt enable actions
	typedef enum logic [1:0] {
		CPSR_IE_NONE,
		CPSR_IE_SET,
		CPSR_IE_CLEAR
	} cpsr_ie_op_t;

	// flags produced by the alu
	typedef struct packed {
		logic h;
		logic v;
		logic n;
		logic z;
		logic c;
	} cpsr_alu_flags_t;

	// alu result write-back request
	typedef struct packed {
		logic                  valid;
		cpsr_scheme_t          scheme;
		logic [REG_AW-1:0]     dest;
		logic [WORD_W-1:0]     result;
		cpsr_alu_flags_t       flags;
		logic [4:0]            flagMask;
	} cpsr_alu_wb_t;

	// data space / io access
	typedef struct packed {
		logic                  read;
		logic                  write;
		logic                  isIo;
		logic [DADDR_W-1:0]    addr;
		logic [DATA_W-1:0]     wdata;
	} cpsr_mem_req_t;

	// instruction word from program memory
	typedef struct packed {
		logic                  valid;
		logic [WORD_W-1:0]     word;
	} cpsr_fetch_t;

endpackage

// File: cpsr_regmem.sv
// module: 32 x 8 working register array with two read ports and a paired write port
`timescale 1ns/10ps
module cpsr_regmem
	import cpsr_pkg::*;
#(
	parameter int COUNT = REG_COUNT,
	parameter int AW    = REG_AW
)(
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic [AW-1:0]     rdAddrA,
	input  wire logic [AW-1:0]     rdAddrB,
	output logic      [DATA_W-1:0] rdDataA,
	output logic      [DATA_W-1:0] rdDataA1,
	output logic      [DATA_W-1:0] rdDataB,
	input  wire logic              wrLow,
	input  wire logic              wrHigh,
	input  wire logic [AW-1:0]     wrAddr,
	input  wire logic [WORD_W-1:0] wrData
);

	logic [DATA_W-1:0] cells [COUNT];
	wire  [AW-1:0]     rdAddrA1 = rdAddrA | AW'(1);
	wire  [AW-1:0]     wrAddr1  = wrAddr | AW'(1);

	//------------------------------------------------------------
	// storage: low and high bytes of a pair land on one edge
	//------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < COUNT; i++)
				cells[i] <= '0;
		end
		else
		begin
			if (wrLow)
				cells[wrAddr] <= wrData[DATA_W-1:0];
			if (wrHigh)
				cells[wrAddr1] <= wrData[WORD_W-1:DATA_W];
		end
	end

	//------------------------------------------------------------
	// registered reads, no bypass: a write shows on the next read
	//------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdDataA  <= '0;
			rdDataA1 <= '0;
			rdDataB  <= '0;
		end
		else
		begin
			rdDataA  <= cells[rdAddrA];
			rdDataA1 <= cells[rdAddrA1];
			rdDataB  <= cells[rdAddrB];
		end
	end

endmodule // cpsr_regmem

// File: cpsr_core.sv
// module: cpu core state: fetch overlap, register file port schemes, data map, status flags
`timescale 1ns/10ps

// Notes on behaviour
// - fetch the next instruction word while the current one executes
// - thirty-two 8-bit working registers, single cycle access
// - two operands out, result written back, one cycle per operation
// - registers 0x1a..0x1f form three 16-bit pointers, low byte even
// - data addresses 0..31 reach the working registers
// - sixty-four io addresses sit at data addresses 0x20..0x5f
// - direct io uses 0x00..0x3f, data space adds 0x20
// - status flags at io 0x3f, data 0x5f, reset 0x00, read/write except sign bit, which follows N xor V
// - no interrupt taken while global enable is clear
// - taking an interrupt clears global enable, return sets it
// - dedicated instructions set and clear global enable
// - bit store copies register bit to flag, bit load copies back
// - sign flag always equals negative xor overflow
// - half carry records carry out of low nibble
// - overflow marks two's complement overflow
// - negative, zero and carry flags mark result properties
// - flags selected by flagMask updated after every alu operation
// - lowest vector number wins among pending interrupts
// - four port schemes: 8/8, 8+8/8, 8+8/16, 16/16
// - return address pushed on stack in data sram
// - instructions are one or two 16-bit words
// - stack grows downward, push decrements the pointer
module cpsr_core
	import cpsr_pkg::*;
#(
	parameter int IRQS = IRQ_COUNT
)(
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	// program memory
	input  wire cpsr_fetch_t           fetchIn,
	input  wire logic                  fetchTwoWord,
	output logic       [WORD_W-1:0]    fetchAddr,
	output logic       [WORD_W-1:0]    instrWord,
	output logic                       instrValid,
	// operand selection and alu write-back
	input  wire logic [REG_AW-1:0]     srcA,
	input  wire logic [REG_AW-1:0]     srcB,
	input  wire cpsr_alu_wb_t          aluWb,
	output logic       [WORD_W-1:0]    operandA,
	output logic       [DATA_W-1:0]    operandB,
	// bit copy instructions
	input  wire logic                  bitStore,
	input  wire logic                  bitLoad,
	input  wire logic [2:0]            bitSel,
	input  wire logic [REG_AW-1:0]     bitReg,
	// interrupt enable instructions and requests
	input  wire cpsr_ie_op_t           ieOp,
	input  wire logic                  returnFromInterrupt,
	input  wire logic [IRQS-1:0]       irqPending,
	output logic                       irqTaken,
	output logic       [IRQ_IDX_W-1:0] irqVector,
	// data space and io access
	input  wire cpsr_mem_req_t         memReq,
	output logic       [DATA_W-1:0]    memRdata,
	output logic                       sramPush,
	output logic       [WORD_W-1:0]    sramPushAddr,
	output logic       [WORD_W-1:0]    sramPushData,
	output logic       [WORD_W-1:0]    pointerX,
	output logic       [WORD_W-1:0]    pointerY,
	output logic       [WORD_W-1:0]    pointerZ,
	output logic       [DATA_W-1:0]    cpuStatusFlags
);

	//------------------------------------------------------------
	// helper functions
	//------------------------------------------------------------
	function automatic logic [IRQ_IDX_W-1:0] lowestSet(input logic [IRQS-1:0] v);
		logic [IRQ_IDX_W-1:0] idx;
		idx = '0;
		for (int i = IRQS - 1; i >= 0; i--)
			if (v[i])
				idx = IRQ_IDX_W'(i);
		return idx;
	endfunction

	function automatic logic [DATA_W-1:0] setBit(input logic [DATA_W-1:0] v, input logic [2:0] sel,
		input logic b);
		logic [DATA_W-1:0] r;
		r = v;
		r[sel] = b;
		return r;
	endfunction

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic [WORD_W-1:0]  pc;
	logic [WORD_W-1:0]  stackTopPointer;
	logic [DATA_W-1:0]  next_status;
	logic [DATA_W-1:0]  rdA;
	logic [DATA_W-1:0]  rdA1;
	logic [DATA_W-1:0]  rdB;
	logic               wrLow;
	logic               wrHigh;
	logic [REG_AW-1:0]  wrAddr;
	logic [WORD_W-1:0]  wrData;
	logic               bitLoadPend;
	logic [2:0]         bitLoadSel;
	logic [REG_AW-1:0]  bitLoadReg;

	//------------------------------------------------------------
	// address decode
	//------------------------------------------------------------
	wire  [DADDR_W-1:0] dsAddr     = memReq.isIo ? memReq.addr + DS_IO_BASE : memReq.addr;
	wire                dsIsReg    = dsAddr <= DS_REG_LAST;
	wire                dsIsIo     = dsAddr >= DS_IO_BASE && dsAddr <= DS_IO_LAST;
	wire  [IOADDR_W-1:0] ioOff     = IOADDR_W'(dsAddr - DS_IO_BASE);
	wire                hitStatus  = dsIsIo && ioOff == IO_STATUS_FLAGS;
	wire                memWrReg   = memReq.write && dsIsReg;
	wire                memWrStat  = memReq.write && hitStatus;
	wire  [REG_AW-1:0]  memRegIdx  = REG_AW'(dsAddr);

	//------------------------------------------------------------
	// interrupt selection
	//------------------------------------------------------------
	wire                irqAccept  = cpuStatusFlags[FLAG_I] && (|irqPending);
	wire  [IRQ_IDX_W-1:0] irqIdx   = lowestSet(irqPending);

	//------------------------------------------------------------
	// register file write port selection
	//------------------------------------------------------------
	wire                aluWide    = aluWb.scheme == CPSR_TWO8_RES16 ||
	                                 aluWb.scheme == CPSR_ONE16_RES16;
	wire  [DATA_W-1:0]  bitLoadVal = setBit(rdB, bitLoadSel, cpuStatusFlags[FLAG_T]);

	always_comb
	begin
		wrLow  = 1'b0;
		wrHigh = 1'b0;
		wrAddr = '0;
		wrData = '0;
		if (aluWb.valid)
		begin
			wrLow  = 1'b1;
			wrHigh = aluWide;
			wrAddr = aluWide ? {aluWb.dest[REG_AW-1:1], 1'b0} : aluWb.dest;
			wrData = aluWb.result;
		end
		else if (bitLoadPend)
		begin
			wrLow  = 1'b1;
			wrAddr = bitLoadReg;
			wrData = {{(WORD_W-DATA_W){1'b0}}, bitLoadVal};
		end
		else if (memWrReg)
		begin
			wrLow  = 1'b1;
			wrAddr = memRegIdx;
			wrData = {{(WORD_W-DATA_W){1'b0}}, memReq.wdata};
		end
	end

	// read port b serves the bit copy register, then a data-space register read, otherwise the second operand
	wire  [REG_AW-1:0]  portBAddr  = bitStore ? bitReg : (bitLoad ? bitReg :
	                                 (memReq.read && dsIsReg ? memRegIdx : srcB));

	cpsr_regmem #(
		.COUNT (REG_COUNT),
		.AW    (REG_AW)
	) u_regmem (
		.mclk     (mclk),
		.rstn     (rstn),
		.rdAddrA  (srcA),
		.rdAddrB  (portBAddr),
		.rdDataA  (rdA),
		.rdDataA1 (rdA1),
		.rdDataB  (rdB),
		.wrLow    (wrLow),
		.wrHigh   (wrHigh),
		.wrAddr   (wrAddr),
		.wrData   (wrData)
	);

	//------------------------------------------------------------
	// status flags next value
	//------------------------------------------------------------
	logic bitStorePend;
	logic [2:0] bitStoreSel;

	always_comb
	begin
		next_status = cpuStatusFlags;
		if (memWrStat)
			next_status = memReq.wdata;
		if (aluWb.valid)
		begin
			if (aluWb.flagMask[4]) next_status[FLAG_H] = aluWb.flags.h;
			if (aluWb.flagMask[3]) next_status[FLAG_V] = aluWb.flags.v;
			if (aluWb.flagMask[2]) next_status[FLAG_N] = aluWb.flags.n;
			if (aluWb.flagMask[1]) next_status[FLAG_Z] = aluWb.flags.z;
			if (aluWb.flagMask[0]) next_status[FLAG_C] = aluWb.flags.c;
		end
		if (bitStorePend)
			next_status[FLAG_T] = rdB[bitStoreSel];
		if (ieOp == CPSR_IE_SET || returnFromInterrupt)
			next_status[FLAG_I] = 1'b1;
		else if (ieOp == CPSR_IE_CLEAR)
			next_status[FLAG_I] = 1'b0;
		if (irqAccept)
			next_status[FLAG_I] = 1'b0;
		next_status[FLAG_S] = next_status[FLAG_N] ^ next_status[FLAG_V];
	end

	//------------------------------------------------------------
	// fetch overlap and program counter
	//------------------------------------------------------------
	wire  [WORD_W-1:0]  pcStep     = fetchTwoWord ? PC_STEP2 : PC_STEP1;
	wire  [WORD_W-1:0]  next_pc    = irqAccept ? WORD_W'(irqIdx) :
	                                 (fetchIn.valid ? pc + pcStep : pc);

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc         <= PC_RESET;
			fetchAddr  <= PC_RESET;
			instrWord  <= '0;
			instrValid <= 1'b0;
		end
		else
		begin
			pc         <= next_pc;
			fetchAddr  <= next_pc;
			instrWord  <= fetchIn.word;
			instrValid <= fetchIn.valid && !irqAccept;
		end
	end

	//------------------------------------------------------------
	// status, bit copy and interrupt state
	//------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			cpuStatusFlags <= STATUS_RESET;
			bitStorePend   <= 1'b0;
			bitStoreSel    <= '0;
			bitLoadPend    <= 1'b0;
			bitLoadSel     <= '0;
			bitLoadReg     <= '0;
			irqTaken       <= 1'b0;
			irqVector      <= '0;
		end
		else
		begin
			cpuStatusFlags <= next_status;
			bitStorePend   <= bitStore;
			bitStoreSel    <= bitSel;
			bitLoadPend    <= bitLoad;
			bitLoadSel     <= bitSel;
			bitLoadReg     <= bitReg;
			irqTaken       <= irqAccept;
			irqVector      <= irqIdx;
		end
	end

	//------------------------------------------------------------
	// stack push of return address
	//------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			stackTopPointer <= STACK_RESET;
			sramPush        <= 1'b0;
			sramPushAddr    <= STACK_RESET;
			sramPushData    <= '0;
		end
		else
		begin
			sramPush <= irqAccept;
			if (irqAccept)
			begin
				sramPushAddr    <= stackTopPointer;
				sramPushData    <= pc;
				stackTopPointer <= stackTopPointer - PC_STEP2;
			end
		end
	end

	//------------------------------------------------------------
	// operands, read data and pointer pairs
	//------------------------------------------------------------
	logic               rdWasStatus;
	logic               rdWasReg;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdWasStatus <= 1'b0;
			rdWasReg    <= 1'b0;
			pointerX    <= '0;
			pointerY    <= '0;
			pointerZ    <= '0;
		end
		else
		begin
			rdWasStatus <= memReq.read && hitStatus;
			rdWasReg    <= memReq.read && dsIsReg;
			if (wrLow && wrAddr == PTR_X_LOW)
				pointerX <= wrHigh ? wrData : {pointerX[WORD_W-1:DATA_W], wrData[DATA_W-1:0]};
			else if (wrLow && wrAddr == (PTR_X_LOW | REG_AW'(1)))
				pointerX <= {wrData[DATA_W-1:0], pointerX[DATA_W-1:0]};
			if (wrLow && wrAddr == PTR_Y_LOW)
				pointerY <= wrHigh ? wrData : {pointerY[WORD_W-1:DATA_W], wrData[DATA_W-1:0]};
			else if (wrLow && wrAddr == (PTR_Y_LOW | REG_AW'(1)))
				pointerY <= {wrData[DATA_W-1:0], pointerY[DATA_W-1:0]};
			if (wrLow && wrAddr == PTR_Z_LOW)
				pointerZ <= wrHigh ? wrData : {pointerZ[WORD_W-1:DATA_W], wrData[DATA_W-1:0]};
			else if (wrLow && wrAddr == (PTR_Z_LOW | REG_AW'(1)))
				pointerZ <= {wrData[DATA_W-1:0], pointerZ[DATA_W-1:0]};
		end
	end

	// one-cycle registered view of memory read data and operands
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			memRdata <= '0;
			operandA <= '0;
			operandB <= '0;
		end
		else
		begin
			memRdata <= rdWasStatus ? cpuStatusFlags : (rdWasReg ? rdB : '0);
			operandA <= {rdA1, rdA};
			operandB <= rdB;
		end
	end

endmodule // cpsr_core

// File: cpsr_core_asserts.sv
// checker: port-level properties of the cpu core state block
`timescale 1ns/10ps
module cpsr_core_asserts
	import cpsr_pkg::*;
#(
	parameter int IRQS = IRQ_COUNT
)(
	input wire logic                 mclk,
	input wire logic                 rstn,
	input wire cpsr_fetch_t          fetchIn,
	input wire logic [WORD_W-1:0]    instrWord,
	input wire logic                 instrValid,
	input wire cpsr_alu_wb_t         aluWb,
	input wire logic                 bitStore,
	input wire logic                 bitLoad,
	input wire cpsr_ie_op_t          ieOp,
	input wire logic                 returnFromInterrupt,
	input wire logic [IRQS-1:0]      irqPending,
	input wire logic                 irqTaken,
	input wire logic [IRQ_IDX_W-1:0] irqVector,
	input wire cpsr_mem_req_t        memReq,
	input wire logic                 sramPush,
	input wire logic [WORD_W-1:0]    sramPushData,
	input wire logic [WORD_W-1:0]    fetchAddr,
	input wire logic [WORD_W-1:0]    pointerX,
	input wire logic [DATA_W-1:0]    cpuStatusFlags
);
	//------------------------------------------------------------
	// helpers and sequences
	//------------------------------------------------------------
	wire logic stWr    = memReq.write && (memReq.isIo ? memReq.addr == 16'h003f : memReq.addr == 16'h005f);
	wire logic quiet   = !aluWb.valid && ieOp == CPSR_IE_NONE && !returnFromInterrupt && !bitStore && !bitLoad;
	wire logic wide    = aluWb.scheme == CPSR_TWO8_RES16 || aluWb.scheme == CPSR_ONE16_RES16;
	wire logic retOnly = returnFromInterrupt && ieOp == CPSR_IE_NONE && !memReq.write;
	wire logic clrOnly = ieOp == CPSR_IE_CLEAR && !returnFromInterrupt && !memReq.write;
	wire logic accept  = cpuStatusFlags[FLAG_I] && (|irqPending);

	function automatic logic [IRQ_IDX_W-1:0] lowIdx(input logic [IRQS-1:0] p);
		lowIdx = '0;
		for (int i = IRQS - 1; i >= 0; i--)
			if (p[i])
				lowIdx = i[IRQ_IDX_W-1:0];
	endfunction

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence sAccept;
		accept;
	endsequence
	sequence sStatusWrite;
		!bitStore ##1 (stWr && quiet && !cpuStatusFlags[FLAG_I]);
	endsequence
	sequence sPairWrite;
		(aluWb.valid && wide && aluWb.dest[4:1] == 4'hd && !bitLoad) ##1 (!aluWb.valid && !memReq.write);
	endsequence

	//------------------------------------------------------------
	// properties
	//------------------------------------------------------------
	AST_SIGN: assert property (cpuStatusFlags[FLAG_S] == (cpuStatusFlags[FLAG_N] ^ cpuStatusFlags[FLAG_V]))
		else $error("sign flag is not negative xor overflow");
	AST_IE_GATE: assert property (!cpuStatusFlags[FLAG_I] |=> !irqTaken)
		else $error("interrupt taken while global enable clear");
	AST_PRIORITY: assert property (sAccept |=> irqTaken && irqVector == lowIdx($past(irqPending)))
		else $error("pending interrupt not taken at lowest index");
	AST_TAKE_EFFECT: assert property (irqTaken |-> !cpuStatusFlags[FLAG_I] && sramPush && fetchAddr == 16'(irqVector))
		else $error("interrupt entry did not clear enable, push and jump");
	AST_PUSH_PC: assert property (sAccept |=> sramPushData == $past(fetchAddr))
		else $error("pushed return address is not the interrupted pc");
	AST_RETURN: assert property (retOnly && !cpuStatusFlags[FLAG_I] |=> cpuStatusFlags[FLAG_I])
		else $error("return did not set global enable");
	AST_IE_CLEAR: assert property (clrOnly |=> !cpuStatusFlags[FLAG_I])
		else $error("clear instruction left global enable set");
	AST_FETCH: assert property (fetchIn.valid && !accept |=> instrValid && instrWord == $past(fetchIn.word))
		else $error("fetched word not captured");
	AST_STATUS_WR: assert property (sStatusWrite |=> cpuStatusFlags ==
		{$past(memReq.wdata[7:5]), ^$past(memReq.wdata[3:2]), $past(memReq.wdata[3:0])})
		else $error("status write not taken");
	AST_ALU_FLAGS: assert property (aluWb.valid && aluWb.flagMask == 5'h1f && !memReq.write |=>
		{cpuStatusFlags[5], cpuStatusFlags[3:0]} == $past(aluWb.flags))
		else $error("alu flags not loaded");
	AST_PAIR: assert property (sPairWrite |=> pointerX == $past(aluWb.result, 2))
		else $error("pair write did not reach pointer");
endmodule // cpsr_core_asserts

bind cpsr_core cpsr_core_asserts #(.IRQS(IRQS)) uChk (
	.mclk(mclk), .rstn(rstn), .fetchIn(fetchIn), .instrWord(instrWord), .instrValid(instrValid), .aluWb(aluWb),
	.bitStore(bitStore), .bitLoad(bitLoad), .ieOp(ieOp), .returnFromInterrupt(returnFromInterrupt),
	.irqPending(irqPending), .irqTaken(irqTaken), .irqVector(irqVector), .memReq(memReq), .sramPush(sramPush),
	.sramPushData(sramPushData), .fetchAddr(fetchAddr), .pointerX(pointerX), .cpuStatusFlags(cpuStatusFlags)
);

// File: cpsr_core_test.sv
// testbench: self-checking run of the cpu core state and register file
`timescale 1ns/10ps
module cpsr_core_test;
	import cpsr_pkg::*;
	//------------------------------------------------------------
	// signals and bench state
	//------------------------------------------------------------
	logic                 mclk = 1'b0;
	logic                 rstn = 1'b0;
	cpsr_fetch_t          fetchIn = '0;
	cpsr_alu_wb_t         aluWb = '0;
	cpsr_mem_req_t        memReq = '0;
	cpsr_ie_op_t          ieOp = CPSR_IE_NONE;
	logic                 fetchTwoWord = 1'b0, bitStore = 1'b0, bitLoad = 1'b0, returnFromInterrupt = 1'b0;
	logic [2:0]           bitSel = 3'h0;
	logic [REG_AW-1:0]    srcA = 5'h00, srcB = 5'h00, bitReg = 5'h00;
	logic [IRQ_COUNT-1:0] irqPending = 8'h00;
	logic [WORD_W-1:0]    fetchAddr, instrWord, operandA, sramPushAddr, sramPushData, pointerX, pointerY, pointerZ;
	logic [DATA_W-1:0]    operandB, memRdata, cpuStatusFlags;
	logic [IRQ_IDX_W-1:0] irqVector;
	logic                 instrValid, irqTaken, sramPush;
	logic [31:0]          seed = 32'h6b4c;
	logic [7:0]           mreg [REG_COUNT];
	logic [7:0]           st = 8'h00, w;
	logic [15:0]          sp = STACK_RESET, pc = PC_RESET;
	int                   nMismatch = 0, checksDone = 0;

	cpsr_core #(.IRQS(IRQ_COUNT)) dut (
		.mclk(mclk), .rstn(rstn), .fetchIn(fetchIn), .fetchTwoWord(fetchTwoWord), .fetchAddr(fetchAddr),
		.instrWord(instrWord), .instrValid(instrValid), .srcA(srcA), .srcB(srcB), .aluWb(aluWb),
		.operandA(operandA), .operandB(operandB), .bitStore(bitStore), .bitLoad(bitLoad), .bitSel(bitSel),
		.bitReg(bitReg), .ieOp(ieOp), .returnFromInterrupt(returnFromInterrupt), .irqPending(irqPending),
		.irqTaken(irqTaken), .irqVector(irqVector), .memReq(memReq), .memRdata(memRdata), .sramPush(sramPush),
		.sramPushAddr(sramPushAddr), .sramPushData(sramPushData), .pointerX(pointerX), .pointerY(pointerY),
		.pointerZ(pointerZ), .cpuStatusFlags(cpuStatusFlags)
	);

	always #12.5 mclk = ~mclk;

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// written sign bit is ignored: it follows negative xor overflow
	function automatic logic [7:0] sx(input logic [7:0] v);
		return {v[7:5], v[2] ^ v[3], v[3:0]};
	endfunction
	function automatic logic [2:0] lowIdx(input logic [7:0] p);
		lowIdx = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (p[i])
				lowIdx = i[2:0];
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic closeOut();
		if (nMismatch == 0 && checksDone > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wrReg(input logic [4:0] d, input logic [15:0] v, input cpsr_scheme_t s, input logic [4:0] f,
		input logic [4:0] m);
		logic [4:0] e;
		aluWb = '{valid: 1'b1, scheme: s, dest: d, result: v, flags: cpsr_alu_flags_t'(f), flagMask: m};
		tick(1);
		aluWb.valid = 1'b0;
		tick(1);
		e = (f & m) | ({st[5], st[3:0]} & ~m);
		st = {st[7:6], e[4], e[2] ^ e[3], e[3:0]};
		if (s == CPSR_TWO8_RES16 || s == CPSR_ONE16_RES16)
		begin
			mreg[{d[4:1], 1'b0}] = v[7:0];
			mreg[{d[4:1], 1'b1}] = v[15:8];
		end
		else
			mreg[d] = v[7:0];
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [4:0] b);
		srcA = a;
		srcB = b;
		tick(2);
		chk(operandA, {mreg[a | 5'h01], mreg[a]});
		chk(16'(operandB), 16'(mreg[b]));
	endtask
	task automatic mem(input logic rd, input logic io, input logic [15:0] a, input logic [7:0] v);
		memReq = '{read: rd, write: !rd, isIo: io, addr: a, wdata: v};
		tick(1);
		memReq = '0;
		tick(1);
	endtask
	task automatic bitOp(input logic ld, input logic [4:0] r, input logic [2:0] b);
		srcB = r;
		bitReg = r;
		bitSel = b;
		bitStore = !ld;
		bitLoad = ld;
		tick(1);
		bitStore = 1'b0;
		bitLoad = 1'b0;
		tick(2);
	endtask

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial
	begin
		tick(5);
		rstn = 1'b1;
		chk(16'(cpuStatusFlags), 16'h0000);
		for (int i = 0; i < 32; i++)
			wrReg(5'(i), 16'(rnd()), i[0] ? CPSR_ONE8_RES8 : CPSR_TWO8_RES8, 5'h00, 5'h00);
		for (int i = 0; i < 32; i++)
			rdChk(5'(i), 5'(31 - i));
		for (int p = 2; p >= 0; p--)
			wrReg(5'h1b + 5'(2 * p), 16'(rnd()), p[0] ? CPSR_ONE16_RES16 : CPSR_TWO8_RES16, 5'h00, 5'h00);
		tick(2);
		chk(pointerX, {mreg[5'h1b], mreg[5'h1a]});
		chk(pointerY, {mreg[5'h1d], mreg[5'h1c]});
		chk(pointerZ, {mreg[5'h1f], mreg[5'h1e]});
		for (int i = 0; i < 32; i++)
		begin
			w = 8'(rnd());
			mem(1'b0, 1'b0, 16'(i), w);
			mreg[i] = w;
			mem(1'b1, 1'b0, 16'(i), 8'h00);
			chk(16'(memRdata), 16'(w));
		end
		rdChk(5'h1e, 5'h00);
		mem(1'b1, 1'b1, 16'h0010, 8'h00);
		chk(16'(memRdata), 16'h0000);
		for (int k = 0; k < 8; k++)
		begin
			w = (k == 0) ? 8'h08 : (k == 1) ? 8'h14 : 8'(rnd()) & 8'h7f;
			mem(1'b0, k[0], k[0] ? 16'h003f : 16'h005f, w);
			st = sx(w);
			chk(16'(cpuStatusFlags), 16'(st));
			mem(1'b1, !k[0], k[0] ? 16'h005f : 16'h003f, 8'h00);
			chk(16'(memRdata), 16'(st));
		end
		for (int k = 0; k < 6; k++)
		begin
			w = 8'(rnd());
			wrReg(5'h00, 16'(w), CPSR_ONE8_RES8, w[4:0], k == 0 ? 5'h1f : w[7:3]);
			chk(16'(cpuStatusFlags), 16'(st));
		end
		for (int k = 0; k < 4; k++)
		begin
			w = 8'(rnd());
			bitOp(1'b0, w[4:0], w[7:5]);
			st[6] = mreg[w[4:0]][w[7:5]];
			chk(16'(cpuStatusFlags), 16'(st));
			bitOp(1'b1, ~w[4:0], w[2:0]);
			mreg[~w[4:0]][w[2:0]] = st[6];
			rdChk(~w[4:0], ~w[4:0]);
		end
		ieOp = CPSR_IE_SET;
		tick(1);
		chk(16'(cpuStatusFlags[FLAG_I]), 16'h0001);
		ieOp = CPSR_IE_CLEAR;
		tick(1);
		chk(16'(cpuStatusFlags[FLAG_I]), 16'h0000);
		ieOp = CPSR_IE_NONE;
		irqPending = 8'hff;
		for (int k = 0; k < 3; k++)
		begin
			tick(1);
			chk(16'(irqTaken), 16'h0000);
		end
		for (int k = 0; k < 6; k++)
		begin
			irqPending = 8'h00;
			ieOp = CPSR_IE_SET;
			tick(1);
			ieOp = CPSR_IE_NONE;
			w = (k == 0) ? 8'h80 : (k == 1) ? 8'h06 : 8'(rnd()) | 8'h80;
			irqPending = w;
			tick(1);
			chk({irqTaken, sramPush, cpuStatusFlags[FLAG_I], 10'h000, irqVector}, {3'h6, 10'h000, lowIdx(w)});
			chk(fetchAddr, 16'(lowIdx(w)));
			chk(sramPushData, pc);
			pc = 16'(lowIdx(w));
			chk(sramPushAddr, sp);
			sp = sp - 16'h0002;
			irqPending = 8'h00;
			returnFromInterrupt = 1'b1;
			tick(1);
			returnFromInterrupt = 1'b0;
			chk(16'(cpuStatusFlags[FLAG_I]), 16'h0001);
			chk(16'(cpuStatusFlags[6:0]), 16'(st[6:0]));
		end
		for (int k = 0; k < 6; k++)
		begin
			fetchIn = '{valid: 1'b1, word: 16'(rnd())};
			fetchTwoWord = k[0];
			tick(1);
			chk(instrWord, fetchIn.word);
			chk(16'(instrValid), 16'h0001);
			pc = pc + (k[0] ? 16'h0002 : 16'h0001);
			chk(fetchAddr, pc);
		end
		closeOut();
	end

	initial
	begin
		repeat (4000) @(posedge mclk);
		nMismatch++;
		closeOut();
	end
endmodule // cpsr_core_test
